//--- design/flag_bank.sv
// Special-function interrupt flag and enable registers
// What this block does
// - Watchdog-mode overflow or key violation sets bit 0
// - Power-on or pin reset clears watchdog flag
// - Serial receive flag marks data available
// - Serial transmit flag bit 7 means ready
// - Tick timer flag bit 7, rest unused
// - Own enables gate NMI-class, global does not
`timescale 1ns/1ps
`include "flag_bank_params.svh"

module flag_bank
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire flag_bank_pkg::addr_type   addr,
  input  wire flag_bank_pkg::byte_type   wr_data,
  input  wire logic                      wr_strobe,
  input  wire logic                      rd_strobe,
  output flag_bank_pkg::byte_type        rd_data,
  input  wire logic                      pin_reset_event,
  input  wire logic                      wdt_overflow,
  input  wire logic                      wdt_watchdog_mode,
  input  wire logic                      key_violation,
  input  wire logic                      osc_fault,
  input  wire logic                      pin_nmi_event,
  input  wire logic                      access_violation,
  input  wire logic                      serial_rx_done,
  input  wire logic                      serial_tx_ready,
  input  wire logic                      tick_timer_event,
  input  wire logic                      global_int_enable,
  output logic                           nmi_request,
  output logic                           watchdog_irq,
  output logic                           serial_rx_irq,
  output logic                           serial_tx_irq,
  output logic                           tick_timer_irq,
  output logic                           watchdog_reset
);

  import flag_bank_pkg::*;

  // ***************************************************
  // Pin inputs
  // ***************************************************

  logic pin_reset_sync;
  logic pin_nmi_sync;
  logic pin_nmi_prev_reg;
  logic pin_nmi_rise;

  // Both come straight from the reset/NMI pin
  pin_sync
  #(
    .WIDTH    (2)
  )
  u_pin_sync
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({pin_reset_event, pin_nmi_event}),
    .sync_out ({pin_reset_sync, pin_nmi_sync})
  );

  // Edge detect on the synchronised NMI level
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pin_nmi_prev_reg <= 1'b0;
    else if (clk_en)
      pin_nmi_prev_reg <= pin_nmi_sync;
  end

  assign pin_nmi_rise = pin_nmi_sync & ~pin_nmi_prev_reg;

  // ***************************************************
  // Address decode
  // ***************************************************

  // Byte-wide bank, so one address picks one register
  function automatic reg_sel_type decode(input addr_type a);
    reg_sel_type s;
    s = SEL_NONE;
    case (a)
      `OFS_ENABLES_ONE: s = SEL_ENABLES_ONE;
      `OFS_ENABLES_TWO: s = SEL_ENABLES_TWO;
      `OFS_FLAGS_ONE:   s = SEL_FLAGS_ONE;
      `OFS_FLAGS_TWO:   s = SEL_FLAGS_TWO;
      default:          s = SEL_NONE;
    endcase
    return s;
  endfunction

  reg_sel_type sel;
  logic        wr_flags_one;
  logic        wr_flags_two;
  logic        wr_en_one;
  logic        wr_en_two;

  assign sel          = decode(addr);
  assign wr_flags_one = wr_strobe && (sel == SEL_FLAGS_ONE);
  assign wr_flags_two = wr_strobe && (sel == SEL_FLAGS_TWO);
  assign wr_en_one    = wr_strobe && (sel == SEL_ENABLES_ONE);
  assign wr_en_two    = wr_strobe && (sel == SEL_ENABLES_TWO);

  // Software write merged with hardware set; the set wins
  function automatic logic next_flag(input logic cur, input logic wr,
                                     input logic wbit, input logic set);
    logic n;
    n = wr ? wbit : cur;
    return n | set;
  endfunction

  // ***************************************************
  // Flag register one
  // ***************************************************

  byte_type flags_one_reg;
  byte_type flags_one_next;
  logic     wdt_set;

  // Watchdog mode overflow or key violation
  assign wdt_set = (wdt_overflow & wdt_watchdog_mode) | key_violation;

  always_comb
  begin
    flags_one_next = flags_one_reg;
    flags_one_next[`BIT_WATCHDOG] =
      next_flag(flags_one_reg[`BIT_WATCHDOG], wr_flags_one,
                wr_data[`BIT_WATCHDOG], wdt_set);
    // Pin reset beats everything, flag reads as cleared
    if (pin_reset_sync)
      flags_one_next[`BIT_WATCHDOG] = 1'b0;
    flags_one_next[`BIT_OSC_FAULT] =
      next_flag(flags_one_reg[`BIT_OSC_FAULT], wr_flags_one,
                wr_data[`BIT_OSC_FAULT], osc_fault);
    flags_one_next[`BIT_PIN_NMI] =
      next_flag(flags_one_reg[`BIT_PIN_NMI], wr_flags_one,
                wr_data[`BIT_PIN_NMI], pin_nmi_rise);
    flags_one_next[`BIT_SERIAL_RX] =
      next_flag(flags_one_reg[`BIT_SERIAL_RX], wr_flags_one,
                wr_data[`BIT_SERIAL_RX], serial_rx_done);
    flags_one_next[`BIT_SERIAL_TX] =
      next_flag(flags_one_reg[`BIT_SERIAL_TX], wr_flags_one,
                wr_data[`BIT_SERIAL_TX], serial_tx_ready);
    flags_one_next = flags_one_next & `MASK_FLAGS_ONE;
  end

  // Power-on reset clears the watchdog flag, tx and osc start set
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      flags_one_reg <= `RST_FLAGS_ONE;
    else if (clk_en)
      flags_one_reg <= flags_one_next;
  end

  // ***************************************************
  // Flag register two
  // ***************************************************

  logic tick_flag_reg;

  // Reset byte held at full width so the flag bit is picked, not truncated
  localparam byte_type RST_TWO_BYTE = `RST_FLAGS_TWO;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tick_flag_reg <= RST_TWO_BYTE[`BIT_TICK_TIMER];
    else if (clk_en)
      tick_flag_reg <= next_flag(tick_flag_reg, wr_flags_two,
                                 wr_data[`BIT_TICK_TIMER], tick_timer_event);
  end

  // ***************************************************
  // Enable registers
  // ***************************************************

  byte_type en_one_reg;
  logic     tick_en_reg;

  // Plain storage, unimplemented bits dropped
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      en_one_reg  <= `RST_ENABLES;
      tick_en_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_en_one)
        en_one_reg <= wr_data & `MASK_ENABLES_ONE;
      if (wr_en_two)
        tick_en_reg <= wr_data[`BIT_TICK_TIMER];
    end
  end

  // ***************************************************
  // Read port
  // ***************************************************

  byte_type rd_mux;

  // Unmapped addresses read zero
  always_comb
  begin
    case (sel)
      SEL_ENABLES_ONE: rd_mux = en_one_reg;
      SEL_ENABLES_TWO: rd_mux = {tick_en_reg, 7'h00};
      SEL_FLAGS_ONE:   rd_mux = flags_one_reg;
      SEL_FLAGS_TWO:   rd_mux = {tick_flag_reg, 7'h00};
      default:         rd_mux = 8'h00;
    endcase
  end

  // Data valid only the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rd_data <= 8'h00;
    else if (clk_en)
      rd_data <= rd_strobe ? rd_mux : 8'h00;
  end

  // ***************************************************
  // Requests to the core
  // ***************************************************

  logic any_access_viol;

  // Access violation flag lives in the flash block; only gated here
  assign any_access_viol = access_violation & en_one_reg[`BIT_ACCESS_VIOL];

  // Global enable deliberately not part of this term
  assign nmi_request =
    (flags_one_reg[`BIT_OSC_FAULT] & en_one_reg[`BIT_OSC_FAULT]) |
    (flags_one_reg[`BIT_PIN_NMI] & en_one_reg[`BIT_PIN_NMI]) |
    any_access_viol;

  // Interval-timer use only; in watchdog mode the flag causes reset
  assign watchdog_irq   = global_int_enable & ~wdt_watchdog_mode &
                          flags_one_reg[`BIT_WATCHDOG] & en_one_reg[`BIT_WATCHDOG];
  assign serial_rx_irq  = global_int_enable &
                          flags_one_reg[`BIT_SERIAL_RX] & en_one_reg[`BIT_SERIAL_RX];
  assign serial_tx_irq  = global_int_enable &
                          flags_one_reg[`BIT_SERIAL_TX] & en_one_reg[`BIT_SERIAL_TX];
  assign tick_timer_irq = global_int_enable & tick_flag_reg & tick_en_reg;
  assign watchdog_reset = wdt_watchdog_mode & flags_one_reg[`BIT_WATCHDOG];

endmodule

//--- design/pin_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps

module pin_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_reg;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      first_reg <= '0;
      sync_out  <= '0;
    end
    else if (clk_en)
    begin
      first_reg <= async_in;
      sync_out  <= first_reg;
    end
  end

endmodule

//--- inc/flag_bank_params.svh
// Register offsets, field positions, reset values for the interrupt flag bank
`ifndef FLAG_BANK_PARAMS_SVH
`define FLAG_BANK_PARAMS_SVH

// Byte offsets
`define OFS_ENABLES_ONE     8'h00
`define OFS_ENABLES_TWO     8'h01
`define OFS_FLAGS_ONE       8'h02
`define OFS_FLAGS_TWO       8'h03

// Field positions in the first flag and enable registers
`define BIT_WATCHDOG        0
`define BIT_OSC_FAULT       1
`define BIT_PIN_NMI         4
`define BIT_ACCESS_VIOL     5
`define BIT_SERIAL_RX       6
`define BIT_SERIAL_TX       7
// Field position in the second flag and enable registers
`define BIT_TICK_TIMER      7

// Reset values
`define RST_FLAGS_ONE       8'h82
`define RST_FLAGS_TWO       8'h00
`define RST_ENABLES         8'h00

// Implemented bits
`define MASK_FLAGS_ONE      8'hD3
`define MASK_ENABLES_ONE    8'hF3
`define MASK_TWO            8'h80

`endif

//--- inc/flag_bank_pkg.sv
// Types shared by the interrupt flag bank
package flag_bank_pkg;

  typedef logic [7:0] byte_type;
  typedef logic [7:0] addr_type;

  // Which register an address selects
  typedef enum
  {
    SEL_NONE,
    SEL_ENABLES_ONE,
    SEL_ENABLES_TWO,
    SEL_FLAGS_ONE,
    SEL_FLAGS_TWO
  } reg_sel_type;

endpackage

//--- sim/cpu_bus_model.sv
// Processor-side model of the byte-wide register bus
`timescale 1ns/1ps
module cpu_bus_model
  import flag_bank_pkg::*;
(
  input  wire logic     ref_clk,
  output addr_type      addr,
  output byte_type      wr_data,
  output logic          wr_strobe,
  output logic          rd_strobe,
  input  wire byte_type rd_data
);
  // ****
  // Bus cycles
  // ****
  // Idle bus from time zero
  initial {addr, wr_data, wr_strobe, rd_strobe} = '0;
  // Single byte write, never a word pair
  task automatic wr(input addr_type a, input byte_type w);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= w;
    wr_strobe <= 1'b1;
    @(posedge ref_clk);
    wr_strobe <= 1'b0;
    wr_data <= ~w; // Released data must not look valid
  endtask
  // Single byte read, data taken in the following cycle
  task automatic rd(input addr_type a, output byte_type r);
    @(posedge ref_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge ref_clk);
    rd_strobe <= 1'b0;
    #1 r = rd_data;
  endtask
endmodule

//--- sim/flag_bank_assertions.sv
// Port-level checks on the interrupt flag bank
`timescale 1ns/1ps
`include "flag_bank_params.svh"
module flag_bank_checker
  import flag_bank_pkg::*;
(
  input wire logic     ref_clk, rst, clk_en, wr_strobe, rd_strobe,
  input wire addr_type addr,
  input wire byte_type wr_data, rd_data,
  input wire logic     pin_reset_event, wdt_overflow, wdt_watchdog_mode, key_violation,
  input wire logic     osc_fault, pin_nmi_event, access_violation, serial_rx_done,
  input wire logic     serial_tx_ready, tick_timer_event, global_int_enable,
  input wire logic     nmi_request, watchdog_irq, serial_rx_irq, serial_tx_irq,
  input wire logic     tick_timer_irq, watchdog_reset
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Reads of each flag register
  wire rd1 = rd_strobe && addr == `OFS_FLAGS_ONE;
  wire rd2 = rd_strobe && addr == `OFS_FLAGS_TWO;
  rd_idle_a: assert property (!rd_strobe |=> rd_data == 8'h00)
    else $error("read data not idle");
  // Pin low long enough that its synchroniser cannot mask the set
  wdt_set_a: assert property ((!pin_reset_event)[*3] ##0
    ((wdt_overflow || key_violation) && wdt_watchdog_mode) |=>
    watchdog_reset || !wdt_watchdog_mode) else $error("watchdog flag not set");
  pin_clr_a: assert property (pin_reset_event[*3] |=> !watchdog_reset)
    else $error("pin reset left watchdog flag");
  rx_flag_a: assert property (serial_rx_done ##1 !wr_strobe ##1 rd1 |=> rd_data[6])
    else $error("receive flag missing");
  tx_flag_a: assert property (serial_tx_ready ##1 !wr_strobe ##1 rd1 |=> rd_data[7])
    else $error("transmit flag missing");
  tick_flag_a: assert property (tick_timer_event ##1 !wr_strobe ##1 rd2 |=>
    rd_data == 8'h80) else $error("tick flag register wrong");
  nmi_hold_a: assert property (nmi_request && !wr_strobe && !access_violation
    |=> nmi_request) else $error("nmi flag not sticky");
  wdt_irq_a: assert property (watchdog_irq |-> global_int_enable && !wdt_watchdog_mode)
    else $error("watchdog irq ungated");
  rx_irq_a: assert property (serial_rx_irq |-> global_int_enable)
    else $error("receive irq ungated");
  // Main scenarios reached
  cover property (nmi_request && !global_int_enable);
  cover property (watchdog_reset);
  cover property (tick_timer_irq);
endmodule
bind flag_bank flag_bank_checker chk (.*);

//--- sim/tb_top.sv
// Self-checking bench for the interrupt flag bank
`timescale 1ns/1ps
module tb_top;
  import flag_bank_pkg::*;
  logic ref_clk = 0, rst = 1, clk_en = 1, pin_reset_event = 0, wdt_watchdog_mode = 0;
  logic pin_nmi_event = 0, access_violation = 0, global_int_enable = 0;
  logic [5:0] ev = '0;
  wire logic wdt_overflow, key_violation, osc_fault, serial_rx_done, serial_tx_ready;
  wire logic tick_timer_event;
  addr_type addr;
  byte_type wr_data, rd_data, d;
  logic wr_strobe, rd_strobe, nmi_request, watchdog_irq, serial_rx_irq;
  logic serial_tx_irq, tick_timer_irq, watchdog_reset;
  int mismatches = 0, num_checks = 0;
  typedef struct { addr_type a; byte_type w, e; } row_type;
  row_type rows[8] = '{'{8'h00, 8'hFF, 8'hF3}, '{8'h01, 8'hFF, 8'h80},
    '{8'h02, 8'h00, 8'h00}, '{8'h03, 8'hFF, 8'h80}, '{8'h03, 8'h00, 8'h00},
    '{8'h02, 8'hFF, 8'hD3}, '{8'h02, 8'h00, 8'h00}, '{8'h07, 8'hFF, 8'h00}};
  // Six of the event inputs share one vector so a single task pulses any of them
  assign {tick_timer_event, serial_tx_ready, serial_rx_done, osc_fault, key_violation,
    wdt_overflow} = ev;
  flag_bank dut (.*);
  cpu_bus_model bus (.*);
  // ****
  // Helpers
  // ****
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input byte_type s, e);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic rc(input addr_type a, input byte_type e);
    bus.rd(a, d);
    chk(d, e);
  endtask
  task pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog: the sequence needs well under 1000 cycles
  initial
  begin
    #20000;
    mismatches++;
    give_verdict;
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    foreach (rows[i])
    begin
      bus.wr(rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].e);
    end
    global_int_enable <= 1;
    pulse(3);
    #1 chk(serial_rx_irq, 1);
    rc(8'h02, 8'h40);
    pulse(4);
    #1 chk(serial_tx_irq, 1);
    rc(8'h02, 8'hC0);
    pulse(5);
    #1 chk(tick_timer_irq, 1);
    rc(8'h03, 8'h80);
    global_int_enable <= 0;
    pulse(2);
    #1 chk(nmi_request, 1);
    chk(serial_rx_irq, 0);
    rc(8'h02, 8'hC2);
    bus.wr(8'h00, 8'hF1);
    #1 chk(nmi_request, 0);
    pin_nmi_event <= 1;
    repeat (4) @(posedge ref_clk);
    rc(8'h02, 8'hD2);
    chk(nmi_request, 1);
    bus.wr(8'h02, 8'h00);
    rc(8'h02, 8'h00);
    pin_nmi_event <= 0;
    access_violation <= 1;
    #1 chk(nmi_request, 1);
    access_violation <= 0;
    global_int_enable <= 1;
    pulse(0);
    rc(8'h02, 8'h00);
    pulse(1);
    #1 chk(watchdog_irq, 1);
    wdt_watchdog_mode <= 1;
    #1 chk(watchdog_irq, 0);
    chk(watchdog_reset, 1);
    bus.wr(8'h02, 8'h00);
    pulse(0);
    rc(8'h02, 8'h01);
    pin_reset_event <= 1;
    repeat (4) @(posedge ref_clk);
    #1 chk(watchdog_reset, 0);
    pin_reset_event <= 0;
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    rc(8'h02, 8'h82);
    rc(8'h03, 8'h00);
    rc(8'h00, 8'h00);
    give_verdict;
  end
endmodule
